// ==== verilog/ctbs_pkg.sv ====
// Purpose: constants for the transmit buffer storage block
// Assumes: 32-bit classic wishbone, one word per register
// Notes: word index = byte address / 4
`default_nettype none
package ctbs_pkg;
  // ----------------------------------------
  // register word indices
  // ----------------------------------------
  localparam logic [4:0] IDX_IDR0 = 5'h00;
  localparam logic [4:0] IDX_DATA0 = 5'h04;
  localparam logic [4:0] IDX_LEN = 5'h0C;
  localparam logic [4:0] IDX_PRIORITY_VALUE = 5'h0D;
  localparam logic [4:0] IDX_STHI = 5'h0E;
  localparam logic [4:0] IDX_STLO = 5'h0F;
  localparam logic [4:0] IDX_SEL = 5'h10;
  localparam logic [4:0] IDX_FLAG = 5'h11;
  localparam logic [4:0] IDX_CTRL = 5'h12;
  localparam logic [4:0] IDX_STAT = 5'h13;
  // ----------------------------------------
  // fields and sizes
  // ----------------------------------------
  localparam int NBUF = 3;
  localparam int NSLOT = 13;
  localparam int MAX_BYTES = 8;
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_STAMP_BIT = 1;
  localparam int IDR1_IDE_BIT = 3;
  localparam int IDR1_RTR_BIT = 4;
  localparam int IDR3_RTR_BIT = 0;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [2:0] RST_EMPTY = 3'h7;
  localparam logic [2:0] RST_SEL = 3'h0;
  localparam logic RST_INIT = 1'b1;
  localparam logic RST_STAMP = 1'b0;
  typedef enum logic [0:0] {ST_IDLE, ST_ACTIVE} ctbs_st_t;
endpackage : ctbs_pkg
`default_nettype wire

// ==== verilog/ctbs_top.sv ====
// Purpose: three transmit buffers, local priority pick, time stamps
// Assumes: protocol engine pulses arb, ok, fail and ack delimiter
// Notes: registers sit on a classic wishbone slave, ack after 1 cycle
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
`default_nettype none
module ctbs_top #(
  parameter int TIMER_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [6:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // protocol engine
  input wire logic arb_req,
  input wire logic tx_ok,
  input wire logic tx_fail,
  input wire logic ack_delim_sample,
  input wire logic bit_tick,
  input wire logic [2:0] payload_idx,
  output logic tx_pending,
  output logic [1:0] tx_buf_idx,
  output logic [31:0] tx_ident,
  output logic [3:0] length_code,
  output logic [3:0] tx_nbytes,
  output logic [7:0] payload_byte,
  // status
  output logic [2:0] tx_empty,
  output logic init_mode,
  output logic [TIMER_W-1:0] stamp_now
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    ctbs_pkg::ctbs_st_t st;
    logic [2:0] empty;
    logic [2:0] sel;
    logic init;
    logic stamp_en;
    logic [2:0][12:0][7:0] mem;
    logic [2:0][7:0] priority_value;
    logic [2:0][TIMER_W-1:0] stamp;
    logic [TIMER_W-1:0] timer;
    logic [1:0] act;
    logic ack;
    logic [31:0] rdat;
    logic [7:0] txb;
  } ctbs_state_t;

  ctbs_state_t q;
  ctbs_state_t n;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // bytes carried on the wire for a code
  function automatic logic [3:0] ctbs_nbytes(input logic [3:0] code,
                                            input logic remote);
    if (remote)
      ctbs_nbytes = 4'h0;
    else if (code > 4'(ctbs_pkg::MAX_BYTES))
      ctbs_nbytes = 4'(ctbs_pkg::MAX_BYTES);
    else
      ctbs_nbytes = code;
  endfunction : ctbs_nbytes

  // one-hot select to index
  function automatic logic [1:0] ctbs_index(input logic [2:0] oh);
    if (oh[0])
      ctbs_index = 2'h0;
    else if (oh[1])
      ctbs_index = 2'h1;
    else
      ctbs_index = 2'h2;
  endfunction : ctbs_index

  // lowest set bit only
  function automatic logic [2:0] ctbs_low1(input logic [2:0] v);
    logic [2:0] r;
    r = 3'h0;
    if (v[0])
      r = 3'h1;
    else if (v[1])
      r = 3'h2;
    else if (v[2])
      r = 3'h4;
    ctbs_low1 = r;
  endfunction : ctbs_low1

  // winner: {found, index}
  function automatic logic [2:0] ctbs_pick(input logic [2:0] rdy,
                                          input logic [2:0][7:0] pr);
    logic found;
    logic [1:0] idx;
    logic [7:0] best;
    found = 1'b0;
    idx = 2'h0;
    best = 8'hFF;
    for (int i = 0; i < ctbs_pkg::NBUF; i++)
    begin
      // strict compare keeps the lower index on a tie
      if (rdy[i] && (!found || pr[i] < best))
      begin
        found = 1'b1;
        idx = 2'(i);
        best = pr[i];
      end
    end
    ctbs_pick = {found, idx};
  endfunction : ctbs_pick

  // remote bit sits in idr1, or in idr3 once the extended bit is set
  function automatic logic ctbs_remote(input logic [3:0][7:0] id);
    if (id[1][ctbs_pkg::IDR1_IDE_BIT])
      ctbs_remote = id[3][ctbs_pkg::IDR3_RTR_BIT];
    else
      ctbs_remote = id[1][ctbs_pkg::IDR1_RTR_BIT];
  endfunction : ctbs_remote

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic bus_req;
  logic [4:0] widx;
  logic [1:0] sidx;
  logic win_ok;
  logic [2:0] pick;
  logic [3:0][7:0] act_id;
  logic act_remote;
  logic [3:0] act_code;
  logic [3:0] act_nb;

  assign bus_req = wb_cyc_i && wb_stb_i;
  assign widx = wb_adr_i[6:2];
  assign sidx = ctbs_index(q.sel);
  // window live only for a selected buffer that is empty
  assign win_ok = (|q.sel) && q.empty[sidx];
  // flags and priorities come straight from flops, so one snapshot
  assign pick = ctbs_pick(~q.empty, q.priority_value);
  assign act_id = {q.mem[q.act][3], q.mem[q.act][2],
                   q.mem[q.act][1], q.mem[q.act][0]};
  assign act_remote = ctbs_remote(act_id);
  assign act_code = q.mem[q.act][ctbs_pkg::IDX_LEN][3:0];
  assign act_nb = ctbs_nbytes(act_code, act_remote);

  // ----------------------------------------
  // window and payload helpers
  // ----------------------------------------
  // stamp bytes always show sixteen bits: a narrower timer reads
  // zero-extended, a wider one loses its top bits
  logic [15:0] win_stamp;
  logic [3:0] pay_slot;

  assign win_stamp = 16'(q.stamp[sidx]);
  // data bytes follow the four identifier bytes in each buffer; the length code sits after them
  assign pay_slot = 4'(ctbs_pkg::IDX_DATA0) + {1'b0, payload_idx};

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic [2:0] clr;
    n = q;
    clr = 3'h0;
    n.ack = bus_req && !q.ack;
    n.rdat = 32'h0;
    // read data prepared with the ack
    if (bus_req && !q.ack && !wb_we_i)
    begin
      if (widx < ctbs_pkg::IDX_PRIORITY_VALUE)
      begin
        if (win_ok)
          n.rdat[7:0] = q.mem[sidx][widx[3:0]];
      end
      else
      begin
        case (widx)
          ctbs_pkg::IDX_PRIORITY_VALUE:
            if (win_ok)
              n.rdat[7:0] = q.priority_value[sidx];
          ctbs_pkg::IDX_STHI:
            if (win_ok)
              n.rdat[7:0] = win_stamp[15:8];
          ctbs_pkg::IDX_STLO:
            if (win_ok)
              n.rdat[7:0] = win_stamp[7:0];
          ctbs_pkg::IDX_SEL:
            n.rdat[2:0] = q.sel;
          ctbs_pkg::IDX_FLAG:
            n.rdat[2:0] = q.empty;
          ctbs_pkg::IDX_CTRL:
            n.rdat[1:0] = {q.stamp_en, q.init};
          ctbs_pkg::IDX_STAT:
            n.rdat[2:0] = {q.st == ctbs_pkg::ST_ACTIVE, q.act};
          default:
            n.rdat = 32'h0;
        endcase
      end
    end
    // writes land on the edge where the master sees ack
    // only byte lane 0 carries a register; the other lanes are ignored
    if (bus_req && q.ack && wb_we_i && wb_sel_i[0])
    begin
      if (widx < ctbs_pkg::IDX_PRIORITY_VALUE)
      begin
        if (win_ok)
          n.mem[sidx][widx[3:0]] = wb_dat_i[7:0];
      end
      else
      begin
        case (widx)
          ctbs_pkg::IDX_PRIORITY_VALUE:
            if (win_ok)
              n.priority_value[sidx] = wb_dat_i[7:0];
          // a full buffer cannot be selected; lowest request bit wins
          ctbs_pkg::IDX_SEL:
            n.sel = ctbs_low1(wb_dat_i[2:0] & q.empty);
          ctbs_pkg::IDX_FLAG:
            clr = wb_dat_i[2:0];
          ctbs_pkg::IDX_CTRL:
          begin
            n.init = wb_dat_i[ctbs_pkg::CTRL_INIT_BIT];
            n.stamp_en = wb_dat_i[ctbs_pkg::CTRL_STAMP_BIT];
          end
          default:
            n.init = q.init;
        endcase
      end
    end
    // a buffer on the wire cannot be handed back by software
    n.empty = q.empty & ~clr;
    // timer
    // wrap-around is silent: nothing flags a timer overflow
    if (q.init)
      n.timer = '0;
    else if (bit_tick)
      n.timer = q.timer + 1'b1;
    // engine side
    case (q.st)
      ctbs_pkg::ST_IDLE:
        if (arb_req && pick[2] && !q.init)
        begin
          n.st = ctbs_pkg::ST_ACTIVE;
          n.act = pick[1:0];
        end
      ctbs_pkg::ST_ACTIVE:
      begin
        // a failed frame stays queued; the next arb_req picks again
        if (ack_delim_sample && q.stamp_en)
          n.stamp[q.act] = q.timer;
        if (tx_ok)
        begin
          n.empty[q.act] = 1'b1;
          n.st = ctbs_pkg::ST_IDLE;
        end
        else if (tx_fail)
          n.st = ctbs_pkg::ST_IDLE;
        else if (arb_req && pick[2])
          n.act = pick[1:0];
      end
      default:
        n.st = ctbs_pkg::ST_IDLE;
    endcase
    // only the byte count of the frame is ever presented
    if ({1'b0, payload_idx} < act_nb)
      n.txb = q.mem[q.act][pay_slot];
    else
      n.txb = 8'h00;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // reset does not wait for ce, so a frozen block still comes up clean
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.st <= ctbs_pkg::ST_IDLE;
      q.empty <= ctbs_pkg::RST_EMPTY;
      q.sel <= ctbs_pkg::RST_SEL;
      q.init <= ctbs_pkg::RST_INIT;
      q.stamp_en <= ctbs_pkg::RST_STAMP;
    end
    else if (ce)
    begin
      q <= n;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdat;
  assign tx_pending = (q.st == ctbs_pkg::ST_ACTIVE);
  assign tx_buf_idx = q.act;
  // ident, code and count are muxes of flops, steady while active unless arb_req picks a new buffer
  assign tx_ident = act_id;
  assign length_code = act_code;
  assign tx_nbytes = act_nb;
  assign payload_byte = q.txb;
  assign tx_empty = q.empty;
  assign init_mode = q.init;
  assign stamp_now = q.timer;

endmodule : ctbs_top
`default_nettype wire

// ==== bench/ctbs_top_sva.sv ====
// Purpose: port checks for the transmit buffer block
// Assumes: ce held high
// Notes: bound below the module
`default_nettype none
module ctbs_chk #(
  parameter int TIMER_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bus and engine
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic arb_req,
  input wire logic tx_ok,
  input wire logic bit_tick,
  // state
  input wire logic tx_pending,
  input wire logic [1:0] tx_buf_idx,
  input wire logic [3:0] tx_nbytes,
  input wire logic [2:0] tx_empty,
  input wire logic init_mode,
  input wire logic [TIMER_W-1:0] stamp_now
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_late_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  tmr_init_a:
    assert property (init_mode && $past(init_mode) |-> stamp_now == '0)
    else $error("timer runs in init");
  tmr_step_a:
    assert property (bit_tick && !init_mode ##1 !init_mode |->
      stamp_now == TIMER_W'($past(stamp_now) + 1'b1)) else $error("tick");
  pick_busy_a:
    assert property ($rose(tx_pending) |-> !tx_empty[tx_buf_idx] &&
      tx_buf_idx != 2'h3) else $error("empty buffer picked");
  pick_none_a:
    assert property (arb_req && !tx_pending && (init_mode || &tx_empty)
      |=> !tx_pending) else $error("pick without work");
  done_ok_a:
    assert property (tx_pending && tx_ok |=> !tx_pending &&
      tx_empty[$past(tx_buf_idx)]) else $error("empty not set");
  nbytes_max_a:
    assert property (tx_pending |-> tx_nbytes <= 4'h8) else $error("count");
endmodule : ctbs_chk
bind ctbs_top ctbs_chk #(.TIMER_W(TIMER_W)) u_chk (.clk(clk), .rst_b(rst_b),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .arb_req(arb_req), .tx_ok(tx_ok), .bit_tick(bit_tick),
  .tx_pending(tx_pending), .tx_buf_idx(tx_buf_idx), .tx_nbytes(tx_nbytes),
  .tx_empty(tx_empty), .init_mode(init_mode), .stamp_now(stamp_now));
`default_nettype wire

// ==== bench/ctbs_engine.sv ====
// Purpose: protocol engine stand-in for the buffer block
// Assumes: one frame per go pulse
// Notes: bit tick runs free, one per four clocks
`default_nettype none
module ctbs_engine (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bench control
  input wire logic go,
  input wire logic fail,
  output logic busy,
  // engine pulses
  output logic arb_req,
  output logic tx_ok,
  output logic tx_fail,
  output logic ack_delim_sample,
  output logic bit_tick,
  output logic [2:0] payload_idx
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt;
  logic [1:0] div;
  logic f;
  always_ff @(posedge clk)
  begin
    div <= rst_b ? div + 2'h1 : 2'h0;
    if (!rst_b)
      cnt <= 4'h0;
    else if (go)
      {cnt, f} <= {4'h1, fail};
    else if (busy)
      cnt <= (cnt == 4'hC || tx_fail) ? 4'h0 : cnt + 4'h1;
  end
  assign busy = cnt != 4'h0;
  assign arb_req = cnt == 4'h1;
  assign tx_fail = f && cnt == 4'h6;
  assign ack_delim_sample = !f && cnt == 4'hA;
  assign tx_ok = !f && cnt == 4'hC;
  assign bit_tick = &div;
  assign payload_idx = cnt[2:0];
endmodule : ctbs_engine
`default_nettype wire

// ==== bench/tb.sv ====
// Purpose: self-checking bench for ctbs_top
// Assumes: engine stand-in makes the frame pulses
// Notes: ce and byte enables held constant
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, we = 1'b0, go = 1'b0;
  logic fl = 1'b0, ack, pend, initm, busy, arb, ok, bad, ads, tick;
  logic [6:0] adr = 7'h00;
  logic [31:0] dat = 32'h0, q, rd;
  logic [1:0] bidx, idx_s;
  logic [2:0] pidx, emp;
  logic [3:0] lc, nb, lc_s, nb_s;
  logic [15:0] snow, st_s;
  logic [7:0] pay, pb_s;
  logic [31:0] id, id_s;
  int errors = 0, num_checks = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    if (pend) {idx_s, nb_s, lc_s, id_s} <= {bidx, nb, lc, id};
    // third byte of the frame leaves the store one cycle after its index
    if (pend && pidx == 3'h3) pb_s <= pay;
    if (ads) st_s <= snow;
  end
  ctbs_top DUT (.clk(clk), .rst_b(rst_b), .ce(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .arb_req(arb),
    .tx_ok(ok), .tx_fail(bad), .ack_delim_sample(ads), .bit_tick(tick),
    .payload_idx(pidx), .tx_pending(pend), .tx_buf_idx(bidx),
    .tx_ident(id), .length_code(lc), .tx_nbytes(nb), .payload_byte(pay),
    .tx_empty(emp), .init_mode(initm), .stamp_now(snow));
  ctbs_engine u_eng (.clk(clk), .rst_b(rst_b), .go(go), .fail(fl),
    .busy(busy), .arb_req(arb), .tx_ok(ok), .tx_fail(bad),
    .ack_delim_sample(ads), .bit_tick(tick), .payload_idx(pidx));
  task automatic finish_test;
    if (errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, we, adr, dat} <= {1'b1, w, a, d};
    for (int n = 0; n < 20 && ack !== 1'b1; n++)
      @(posedge clk);
    if (ack !== 1'b1)
      chk(32'h0, 32'h1);
    if (ack !== 1'b1)
      finish_test();
    q = rd;
    cyc <= 1'b0;
  endtask : wb
  task automatic run(input int b, input logic [3:0] n, input logic [3:0] l,
    input logic [7:0] r1);
    logic [7:0] h;
    @(posedge clk);
    go <= 1'b1;
    fl <= b < 0;
    @(posedge clk);
    go <= 1'b0;
    // busy shows only after the edge where the engine takes go
    @(posedge clk);
    for (int i = 0; i < 40 && busy !== 1'b0; i++)
      @(posedge clk);
    if (busy !== 1'b0)
      chk(32'h0, 32'h2);
    if (busy !== 1'b0)
      finish_test();
    chk(32'(idx_s), b < 0 ? 32'h1 : 32'(b));
    if (b < 0)
      return;
    chk(32'(nb_s), 32'(n));
    chk(32'(lc_s), 32'(l));
    chk(id_s, {16'h0, r1, 8'h00});
    chk(32'(pb_s), n > 4'h2 ? 32'h0A0 + 32'(b) : 32'h0);
    chk(32'(emp[b]), 32'h1);
    wb(1'b1, 7'h40, 32'h1 << b);
    wb(1'b0, 7'h38, 32'h0);
    h = q[7:0];
    wb(1'b0, 7'h3C, 32'h0);
    chk({16'h0, h, q[7:0]}, 32'(st_s));
  endtask : run
  task automatic load(input int b, input logic [7:0] p, l, i);
    logic [31:0] s;
    wb(1'b1, 7'h40, 32'h1 << b);
    wb(1'b1, 7'h34, 32'(p));
    wb(1'b0, 7'h34, 32'h0);
    chk(q, 32'(p));
    wb(1'b1, 7'h04, 32'(i));
    wb(1'b1, 7'h18, 32'h0A0 + 32'(b));
    wb(1'b1, 7'h30, 32'(l));
    s = q;
    wb(1'b0, 7'h38, 32'h0);
    s = q;
    wb(1'b1, 7'h38, 32'hFF);
    wb(1'b0, 7'h38, 32'h0);
    chk(q, s);
    wb(1'b1, 7'h44, 32'h1 << b);
    wb(1'b0, 7'h34, 32'h0);
    chk(q, 32'h0);
    chk(32'(emp[b]), 32'h0);
  endtask : load
  task automatic t_reset;
    chk({emp, initm, pend}, 5'h1E);
    chk(32'(snow), 32'h0);
    wb(1'b0, 7'h50, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, 7'h48, 32'h2);
  endtask : t_reset
  task automatic t_queue;
    // remote frame in 0, extended oversize code in 1, tie on 1 and 2
    load(0, 8'h05, 8'h03, 8'h10);
    load(1, 8'h03, 8'h0F, 8'h18);
    load(2, 8'h03, 8'h05, 8'h00);
    run(-1, 4'h0, 4'h0, 8'h00);
    run(1, 4'h8, 4'hF, 8'h18);
    run(2, 4'h5, 4'h5, 8'h00);
    run(0, 4'h0, 4'h3, 8'h10);
  endtask : t_queue
  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_queue();
    finish_test();
  end
endmodule : tb
`default_nettype wire
